// file: src/ssd_pkg.sv
// Shared constants and types for the sleep and monitoring command decoder
package ssd_pkg;
    // ------------------------------------------------------------------
    // Command opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_SLEEP_A = 8'hE6;
    localparam logic [7:0] OP_SLEEP_B = 8'h99;
    localparam logic [7:0] OP_SMART = 8'hB0;

    // ------------------------------------------------------------------
    // Monitoring subcommand codes, carried in the features byte
    // ------------------------------------------------------------------
    localparam logic [7:0] SUB_READ_VALUES = 8'hD0;
    localparam logic [7:0] SUB_READ_THRESH = 8'hD1;
    localparam logic [7:0] SUB_AUTOSAVE = 8'hD2;
    localparam logic [7:0] SUB_SAVE = 8'hD3;
    localparam logic [7:0] SUB_OFFLINE = 8'hD4;
    localparam logic [7:0] SUB_READ_LOG = 8'hD5;
    localparam logic [7:0] SUB_WRITE_LOG = 8'hD6;
    localparam logic [7:0] SUB_ENABLE = 8'hD8;
    localparam logic [7:0] SUB_DISABLE = 8'hD9;
    localparam logic [7:0] SUB_STATUS = 8'hDA;
    localparam logic [7:0] SUB_AUTO_OFFLINE = 8'hDB;

    // ------------------------------------------------------------------
    // Signature bytes and transfer size
    // ------------------------------------------------------------------
    localparam logic [7:0] SIG_CYL_LO = 8'h4F;
    localparam logic [7:0] SIG_CYL_HI = 8'hC2;
    localparam logic [9:0] XFER_BYTES = 10'h200;

    // ------------------------------------------------------------------
    // Flag bit positions and reset values
    // ------------------------------------------------------------------
    localparam int ERR_ABT_BIT = 2;
    localparam int ST_RDY_BIT = 6;
    localparam int ST_DSC_BIT = 4;
    localparam int ST_ERR_BIT = 0;
    localparam logic [7:0] ERR_RESET = 8'h00;
    localparam logic [7:0] STAT_RESET = 8'h50;
    localparam logic SMART_EN_RESET = 1'b0;

    // ------------------------------------------------------------------
    // State encodings
    // ------------------------------------------------------------------
    typedef enum logic [5:0] {
        DEV_IDLE = 6'h01,
        DEV_SPIN = 6'h02,
        DEV_SLEEP = 6'h04,
        DEV_SAVE = 6'h08,
        DEV_XFER = 6'h10,
        DEV_SPARE = 6'h20
    } ssd_dev_state_t;

    typedef enum logic [3:0] {
        HST_IDLE = 4'h1,
        HST_ISSUE = 4'h2,
        HST_WAIT = 4'h4,
        HST_RESET = 4'h8
    } ssd_hst_state_t;
endpackage : ssd_pkg

// file: src/ssd_link_if.sv
// Command block link between host controller and drive decoder
`timescale 1ns/100ps
interface ssd_link_if;
    logic cmd_valid;
    logic cmd_ready;
    logic [7:0] cmd_code;
    logic [7:0] features;
    logic [7:0] sect_cnt;
    logic [7:0] sect_num;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic soft_rst;
    logic done;
    logic [7:0] err_flags;
    logic [7:0] stat_flags;
    logic rd_valid;
    logic rd_ready;
    logic [7:0] rd_byte;

    modport dev (
        input cmd_valid, cmd_code, features, sect_cnt, sect_num,
        input cyl_lo, cyl_hi, soft_rst, rd_ready,
        output cmd_ready, done, err_flags, stat_flags, rd_valid, rd_byte
    );
    modport host (
        output cmd_valid, cmd_code, features, sect_cnt, sect_num,
        output cyl_lo, cyl_hi, soft_rst, rd_ready,
        input cmd_ready, done, err_flags, stat_flags, rd_valid, rd_byte
    );
endinterface : ssd_link_if

// file: src/ssd_device.sv
// Drive end: decodes sleep and monitoring commands, streams 512-byte reads
//
// Notes on behaviour
// - Both sleep opcodes mean one sleep request
// - Accepted sleep enters the lowest power state
// - Sleep stops spindle, link accepts no commands
// - Spindle already stopped: skip spin-down, sleep directly
// - Only soft or hard reset leaves sleep
// - One opcode enters all monitoring subcommands
// - Host loads subcommand into features before opcode; the host end loads both in the same cycle
// - Device decodes the eleven listed subcommand codes
// - Values read: save first, then send 512
// - Thresholds read: fetch, then send 512 bytes
// - No monitoring or saving before enable
// - After disable, all but enable abort
`timescale 1ns/100ps
module ssd_device (
    input wire logic mclk,
    input wire logic sys_rst,
    ssd_link_if.dev link,
    input wire logic spindle_spinning,
    output logic spin_down_req,
    input wire logic spin_down_done,
    output logic save_req,
    input wire logic save_done,
    output logic [8:0] src_addr,
    output logic src_thresh,
    input wire logic [7:0] src_byte,
    output logic monitor_en,
    output logic asleep
);
    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        ssd_pkg::ssd_dev_state_t state;
        logic smart_en;
        logic thresh;
        logic [9:0] cnt;
        logic [7:0] data;
        logic dvalid;
        logic done;
        logic [7:0] err;
        logic [7:0] stat;
    } ssd_dev_t;

    ssd_dev_t s_r;
    ssd_dev_t s_nxt;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Close a command: publish flags, pulse done, return to idle
    function automatic ssd_dev_t finish(input ssd_dev_t x,
                                        input logic abort);
        ssd_dev_t y;
        y = x;
        y.state = ssd_pkg::DEV_IDLE;
        y.done = 1'b1;
        y.dvalid = 1'b0;
        y.err = ssd_pkg::ERR_RESET;
        y.stat = ssd_pkg::STAT_RESET;
        y.err[ssd_pkg::ERR_ABT_BIT] = abort;
        y.stat[ssd_pkg::ST_ERR_BIT] = abort;
        return y;
    endfunction : finish

    // Subcommand codes that the decoder knows
    function automatic logic known_sub(input logic [7:0] f);
        logic k;
        k = 1'b0;
        case (f)
            ssd_pkg::SUB_READ_VALUES, ssd_pkg::SUB_READ_THRESH,
            ssd_pkg::SUB_AUTOSAVE, ssd_pkg::SUB_SAVE,
            ssd_pkg::SUB_OFFLINE, ssd_pkg::SUB_READ_LOG,
            ssd_pkg::SUB_WRITE_LOG, ssd_pkg::SUB_ENABLE,
            ssd_pkg::SUB_DISABLE, ssd_pkg::SUB_STATUS,
            ssd_pkg::SUB_AUTO_OFFLINE: k = 1'b1;
            default: k = 1'b0;
        endcase
        return k;
    endfunction : known_sub

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Commands are taken only in idle; sleep leaves the link deaf
    assign link.cmd_ready = (s_r.state == ssd_pkg::DEV_IDLE);
    assign link.done = s_r.done;
    assign link.err_flags = s_r.err;
    assign link.stat_flags = s_r.stat;
    assign link.rd_valid = s_r.dvalid;
    assign link.rd_byte = s_r.data;
    assign spin_down_req = (s_r.state == ssd_pkg::DEV_SPIN);
    assign save_req = (s_r.state == ssd_pkg::DEV_SAVE);
    assign src_addr = s_r.cnt[8:0];
    assign src_thresh = s_r.thresh;
    assign monitor_en = s_r.smart_en;
    assign asleep = (s_r.state == ssd_pkg::DEV_SLEEP);

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        case (s_r.state)
            ssd_pkg::DEV_IDLE: begin
                if (link.cmd_valid) begin
                    if (link.cmd_code == ssd_pkg::OP_SLEEP_A ||
                        link.cmd_code == ssd_pkg::OP_SLEEP_B) begin
                        if (spindle_spinning) begin
                            s_nxt.state = ssd_pkg::DEV_SPIN;
                        end else begin
                            s_nxt.state = ssd_pkg::DEV_SLEEP;
                        end
                    end else if (link.cmd_code == ssd_pkg::OP_SMART) begin
                        // Features byte chosen by the host selects the op
                        if (link.cyl_lo != ssd_pkg::SIG_CYL_LO ||
                            link.cyl_hi != ssd_pkg::SIG_CYL_HI) begin
                            s_nxt = finish(s_r, 1'b1);
                        end else if (!known_sub(link.features)) begin
                            s_nxt = finish(s_r, 1'b1);
                        end else if (!s_r.smart_en &&
                                     link.features != ssd_pkg::SUB_ENABLE)
                        begin
                            s_nxt = finish(s_r, 1'b1);
                        end else begin
                            case (link.features)
                                ssd_pkg::SUB_READ_VALUES: begin
                                    s_nxt.state = ssd_pkg::DEV_SAVE;
                                    s_nxt.thresh = 1'b0;
                                    s_nxt.cnt = '0;
                                end
                                ssd_pkg::SUB_READ_THRESH: begin
                                    s_nxt.state = ssd_pkg::DEV_XFER;
                                    s_nxt.thresh = 1'b1;
                                    s_nxt.cnt = '0;
                                end
                                ssd_pkg::SUB_ENABLE: begin
                                    s_nxt = finish(s_r, 1'b0);
                                    s_nxt.smart_en = 1'b1;
                                end
                                ssd_pkg::SUB_DISABLE: begin
                                    s_nxt = finish(s_r, 1'b0);
                                    s_nxt.smart_en = 1'b0;
                                end
                                default: begin
                                    // No action for the other known codes; complete cleanly
                                    s_nxt = finish(s_r, 1'b0);
                                end
                            endcase
                        end
                    end else begin
                        s_nxt = finish(s_r, 1'b1);
                    end
                end
            end
            ssd_pkg::DEV_SPIN: begin
                // Hold spin-down request until the spindle reports stopped
                if (spin_down_done) begin
                    s_nxt.state = ssd_pkg::DEV_SLEEP;
                end
            end
            ssd_pkg::DEV_SLEEP: begin
                s_nxt.state = ssd_pkg::DEV_SLEEP;
            end
            ssd_pkg::DEV_SAVE: begin
                // Attribute values go to their sectors before transfer
                if (save_done) begin
                    s_nxt.state = ssd_pkg::DEV_XFER;
                end
            end
            ssd_pkg::DEV_XFER: begin
                // One byte in flight; refill when the host takes it
                if (s_r.dvalid && link.rd_ready) begin
                    s_nxt.dvalid = 1'b0;
                end
                if (!s_nxt.dvalid) begin
                    if (s_r.cnt != ssd_pkg::XFER_BYTES) begin
                        s_nxt.data = src_byte;
                        s_nxt.dvalid = 1'b1;
                        s_nxt.cnt = s_r.cnt + 10'h001;
                    end else begin
                        s_nxt = finish(s_nxt, 1'b0);
                    end
                end
            end
            default: begin
                s_nxt.state = ssd_pkg::DEV_IDLE;
            end
        endcase
        // Soft reset aborts any command and wakes from sleep
        if (link.soft_rst) begin
            s_nxt.state = ssd_pkg::DEV_IDLE;
            s_nxt.dvalid = 1'b0;
            s_nxt.done = 1'b0;
            s_nxt.smart_en = s_r.smart_en; // Enable survives soft reset
            s_nxt.err = ssd_pkg::ERR_RESET;
            s_nxt.stat = ssd_pkg::STAT_RESET;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_r.state <= ssd_pkg::DEV_IDLE;
            s_r.smart_en <= ssd_pkg::SMART_EN_RESET;
            s_r.thresh <= 1'b0;
            s_r.cnt <= '0;
            s_r.data <= 8'h00;
            s_r.dvalid <= 1'b0;
            s_r.done <= 1'b0;
            s_r.err <= ssd_pkg::ERR_RESET;
            s_r.stat <= ssd_pkg::STAT_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : ssd_device

// file: src/ssd_host.sv
// Host end: issues command blocks, collects results and read data
`timescale 1ns/100ps
module ssd_host (
    input wire logic mclk,
    input wire logic sys_rst,
    ssd_link_if.host link,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [7:0] req_code,
    input wire logic [7:0] req_features,
    input wire logic [7:0] req_sect_cnt,
    input wire logic [7:0] req_sect_num,
    input wire logic wake,
    output logic resp_valid,
    output logic [7:0] resp_err,
    output logic [7:0] resp_stat,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [7:0] rx_byte
);
    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        ssd_pkg::ssd_hst_state_t state;
        logic [7:0] code;
        logic [7:0] feat;
        logic [7:0] scnt;
        logic [7:0] snum;
        logic [7:0] clo;
        logic [7:0] chi;
        logic srst;
        logic rvalid;
        logic [7:0] rerr;
        logic [7:0] rstat;
    } ssd_hst_t;

    ssd_hst_t h_r;
    ssd_hst_t h_nxt;

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign req_ready = (h_r.state == ssd_pkg::HST_IDLE);
    assign link.cmd_valid = (h_r.state == ssd_pkg::HST_ISSUE);
    assign link.cmd_code = h_r.code;
    assign link.features = h_r.feat;
    assign link.sect_cnt = h_r.scnt;
    assign link.sect_num = h_r.snum;
    assign link.cyl_lo = h_r.clo;
    assign link.cyl_hi = h_r.chi;
    assign link.soft_rst = h_r.srst;
    assign link.rd_ready = rx_ready;
    assign rx_valid = link.rd_valid;
    assign rx_byte = link.rd_byte;
    assign resp_valid = h_r.rvalid;
    assign resp_err = h_r.rerr;
    assign resp_stat = h_r.rstat;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        h_nxt = h_r;
        h_nxt.srst = 1'b0;
        h_nxt.rvalid = 1'b0;
        case (h_r.state)
            ssd_pkg::HST_IDLE: begin
                if (wake) begin
                    h_nxt.state = ssd_pkg::HST_RESET;
                    h_nxt.srst = 1'b1;
                end else if (req_valid) begin
                    // Features and signature are loaded with the opcode
                    h_nxt.state = ssd_pkg::HST_ISSUE;
                    h_nxt.code = req_code;
                    h_nxt.feat = req_features;
                    h_nxt.scnt = req_sect_cnt;
                    h_nxt.snum = req_sect_num;
                    h_nxt.clo = ssd_pkg::SIG_CYL_LO;
                    h_nxt.chi = ssd_pkg::SIG_CYL_HI;
                end
            end
            ssd_pkg::HST_ISSUE: begin
                if (link.cmd_ready) begin
                    h_nxt.state = ssd_pkg::HST_WAIT;
                end else if (wake) begin
                    h_nxt.state = ssd_pkg::HST_RESET;
                    h_nxt.srst = 1'b1;
                end
            end
            ssd_pkg::HST_WAIT: begin
                // Sleep never completes; only a wake gets out
                if (link.done) begin
                    h_nxt.state = ssd_pkg::HST_IDLE;
                    h_nxt.rvalid = 1'b1;
                    h_nxt.rerr = link.err_flags;
                    h_nxt.rstat = link.stat_flags;
                end else if (wake) begin
                    h_nxt.state = ssd_pkg::HST_RESET;
                    h_nxt.srst = 1'b1;
                end
            end
            ssd_pkg::HST_RESET: begin
                h_nxt.state = ssd_pkg::HST_IDLE;
            end
            default: begin
                h_nxt.state = ssd_pkg::HST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            h_r.state <= ssd_pkg::HST_IDLE;
            h_r.code <= 8'h00;
            h_r.feat <= 8'h00;
            h_r.scnt <= 8'h00;
            h_r.snum <= 8'h00;
            h_r.clo <= 8'h00;
            h_r.chi <= 8'h00;
            h_r.srst <= 1'b0;
            h_r.rvalid <= 1'b0;
            h_r.rerr <= ssd_pkg::ERR_RESET;
            h_r.rstat <= ssd_pkg::STAT_RESET;
        end else begin
            h_r <= h_nxt;
        end
    end
endmodule : ssd_host

// file: testbench/ssd_link_assertions.sv
// Concurrent checks on the command link between host and drive ends
`timescale 1ns/100ps
module ssd_link_assertions (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] features,
    input wire logic soft_rst,
    input wire logic done,
    input wire logic [7:0] err_flags,
    input wire logic [7:0] stat_flags,
    input wire logic rd_valid,
    input wire logic rd_ready,
    input wire logic [7:0] rd_byte
);
    logic [10:0] nbytes_r;
    logic [10:0] nbytes_nxt;
    logic take;

    // Count read bytes accepted since the last command was taken
    assign take = cmd_valid && cmd_ready && !soft_rst;
    always_comb begin
        nbytes_nxt = nbytes_r;
        if (take) begin
            nbytes_nxt = 11'h000;
        end else if (rd_valid && rd_ready) begin
            nbytes_nxt = nbytes_r + 11'h001;
        end
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            nbytes_r <= 11'h000;
        end else begin
            nbytes_r <= nbytes_nxt;
        end
    end

    default clocking @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    AST_OK_FLAGS: assert property (
        done && !err_flags[2] |-> stat_flags == 8'h50 && err_flags == 8'h00)
        else $error("good completion flags wrong");
    AST_ABORT_FLAGS: assert property (
        done && err_flags[2] |-> stat_flags == 8'h51 && err_flags == 8'h04)
        else $error("abort completion flags wrong");
    AST_UNKNOWN_SUB: assert property (
        take && cmd_code == 8'hB0 && (features[7:4] != 4'hD
        || features[3:0] inside {4'h7, [4'hC:4'hF]})
        |=> done && err_flags == 8'h04)
        else $error("unknown subcommand not aborted");
    AST_BAD_OPCODE: assert property (
        take && !(cmd_code inside {8'hE6, 8'h99, 8'hB0})
        |=> done && err_flags == 8'h04)
        else $error("unknown opcode not aborted");
    AST_SLEEP_QUIET: assert property (
        take && cmd_code inside {8'hE6, 8'h99} |=> (!cmd_ready && !done) [*8])
        else $error("link active after sleep");
    AST_SOFT_RST: assert property (
        soft_rst |=> cmd_ready && !rd_valid && stat_flags == 8'h50
        && err_flags == 8'h00)
        else $error("soft reset did not restore idle");
    AST_RD_HOLD: assert property (
        rd_valid && !rd_ready && !soft_rst |=> rd_valid && $stable(rd_byte))
        else $error("read byte dropped before taken");
    AST_DONE_NO_RD: assert property (
        done |-> !rd_valid)
        else $error("read data still offered at completion");
    AST_READ_COUNT: assert property (
        done && nbytes_r != 11'h000 |-> nbytes_r == 11'h200)
        else $error("read length not 512 bytes");
    AST_NO_DATA: assert property (
        done && err_flags[2] |-> nbytes_r == 11'h000)
        else $error("aborted command moved data");
endmodule : ssd_link_assertions

// file: testbench/test_sleep_and_smart_command_decoder.sv
// Self-checking bench joining host and drive ends of the decoder
`timescale 1ns/100ps
module test_sleep_and_smart_command_decoder;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic req_valid = 1'b0;
    logic wake = 1'b0;
    logic rx_ready = 1'b1;
    logic [7:0] req_code = 8'h00, req_features = 8'h00;
    logic [7:0] req_sect_cnt = 8'h00, req_sect_num = 8'h00;
    logic spindle_spinning = 1'b0, spin_down_done = 1'b0, save_done = 1'b0;
    logic req_ready, resp_valid, rx_valid, spin_down_req, save_req;
    logic src_thresh, monitor_en, asleep;
    logic [7:0] resp_err, resp_stat, rx_byte, src_byte;
    logic [8:0] src_addr;
    int fails = 0, checked = 0, cycles = 0, en = 0;
    bit saw_save, saw_spin;
    logic [7:0] exp_q[$];

    ssd_link_if link ();
    ssd_link_if link_b ();
    ssd_host i_ssd_host (.mclk(mclk), .sys_rst(sys_rst), .link(link),
        .req_valid(req_valid), .req_ready(req_ready), .req_code(req_code),
        .req_features(req_features), .req_sect_cnt(req_sect_cnt),
        .req_sect_num(req_sect_num), .wake(wake), .resp_valid(resp_valid),
        .resp_err(resp_err), .resp_stat(resp_stat), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_byte(rx_byte));
    ssd_device i_ssd_device (.mclk(mclk), .sys_rst(sys_rst), .link(link),
        .spindle_spinning(spindle_spinning), .spin_down_req(spin_down_req),
        .spin_down_done(spin_down_done), .save_req(save_req),
        .save_done(save_done), .src_addr(src_addr), .src_thresh(src_thresh),
        .src_byte(src_byte), .monitor_en(monitor_en), .asleep(asleep));
    ssd_device i_ssd_device_b (.mclk(mclk), .sys_rst(sys_rst), .link(link_b),
        .spindle_spinning(spindle_spinning), .spin_down_req(),
        .spin_down_done(spin_down_done), .save_req(), .save_done(save_done),
        .src_addr(), .src_thresh(), .src_byte(src_byte), .monitor_en(),
        .asleep());
    ssd_link_assertions i_ssd_link_assertions (.mclk(mclk), .sys_rst(sys_rst),
        .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready),
        .cmd_code(link.cmd_code), .features(link.features),
        .soft_rst(link.soft_rst), .done(link.done),
        .err_flags(link.err_flags), .stat_flags(link.stat_flags),
        .rd_valid(link.rd_valid), .rd_ready(link.rd_ready),
        .rd_byte(link.rd_byte));

    // Attribute source: value depends on address and table select
    assign src_byte = src_addr[7:0] ^ {src_addr[8], 6'h00, src_thresh};
    always #2 mclk = ~mclk;

    // Far side handshakes with random latency
    always @(negedge mclk) begin
        rx_ready <= $urandom_range(0, 3) != 0;
        save_done <= save_req && $urandom_range(0, 1);
    end

    // Accepted read bytes against the model, plus hang guard
    always @(posedge mclk) begin
        cycles++;
        if (save_req === 1'b1) saw_save = 1'b1;
        if (spin_down_req === 1'b1) saw_spin = 1'b1;
        if (rx_valid === 1'b1 && rx_ready) begin
            check({7'h00, exp_q.size() != 0}, 8'h01, "byte due");
            check(rx_byte, exp_q.size() ? exp_q.pop_front() : 8'h00,
                "byte");
        end
        if (cycles == 20000) begin
            fails++;
            conclude();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp,
        input string what);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error %0t: %s exp %h got %h", $time, what, exp, got);
        end
    endtask : check

    task automatic conclude();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    // Hand one request to the host end and wait until it is taken
    task automatic send(input logic [7:0] c, input logic [7:0] f);
        int n;
        req_code = c;
        req_features = f;
        req_sect_cnt = 8'($urandom);
        req_sect_num = 8'($urandom);
        req_valid = 1'b1;
        n = 0;
        // Ready is looked at while settled, ahead of the taking edge
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge mclk);
            n++;
        end
        @(negedge mclk);
        req_valid = 1'b0;
    endtask : send

    // Run one monitoring or other command and compare with the model
    task automatic run(input logic [7:0] c, input logic [7:0] f);
        int n;
        bit ab;
        ab = c != 8'hB0 || f[7:4] != 4'hD || f[3:0] inside {4'h7, [4'hC:4'hF]}
            || (en == 0 && f != 8'hD8);
        saw_save = 1'b0;
        if (!ab && f inside {8'hD0, 8'hD1}) begin
            for (int k = 0; k < 512; k++) begin
                exp_q.push_back(8'(k) ^ {k[8], 6'h00, f[0]});
            end
        end
        if (!ab && f == 8'hD8) en = 1;
        if (!ab && f == 8'hD9) en = 0;
        send(c, f);
        for (n = 0; n < 2000 && resp_valid !== 1'b1; n++) @(negedge mclk);
        check({7'h00, resp_valid}, 8'h01, "response");
        check(resp_err, ab ? 8'h04 : 8'h00, "error flags");
        check(resp_stat, ab ? 8'h51 : 8'h50, "status flags");
        check({7'h00, saw_save}, {7'h00, !ab && f == 8'hD0}, "save");
        check({7'h00, exp_q.size() != 0}, 8'h00, "bytes left");
        check({7'h00, monitor_en}, 8'(en), "enable");
    endtask : run

    // Drive the second drive end directly with chosen signature bytes
    task automatic probe(input logic [7:0] lo, input logic [7:0] hi);
        link_b.cyl_lo = lo;
        link_b.cyl_hi = hi;
        link_b.cmd_valid = 1'b1;
        @(negedge mclk);
        link_b.cmd_valid = 1'b0;
        // Done stands only in the cycle after the take
        check({7'h00, link_b.done}, 8'h01, "signature done");
        check(link_b.err_flags, (lo == 8'h4F && hi == 8'hC2) ? 8'h00 : 8'h04,
            "signature");
        @(negedge mclk);
    endtask : probe

    // Main sequence
    initial begin
        int n;
        {link_b.cmd_valid, link_b.soft_rst, link_b.rd_ready} = 3'b001;
        {link_b.cmd_code, link_b.features} = 16'hB0D8;
        {link_b.sect_cnt, link_b.sect_num} = 16'h0000;
        {link_b.cyl_lo, link_b.cyl_hi} = 16'h0000;
        void'($urandom(29610));
        repeat (6) @(negedge mclk);
        sys_rst = 1'b0;
        check(link.stat_flags, 8'h50, "reset status");
        run(8'hB0, 8'hD0);
        run(8'hB0, 8'hD8);
        run(8'h37, 8'hD8);
        for (int i = 15; i >= 0; i--) run(8'hB0, 8'hD0 + 8'(i));
        run(8'hB0, 8'hD9);
        run(8'hB0, 8'hD9);
        run(8'hB0, 8'hD8);
        repeat (4) run(8'hB0, 8'($urandom));
        probe(8'h4E, 8'hC2);
        probe(8'h4F, 8'hC3);
        probe(8'h4F, 8'hC2);
        spindle_spinning = 1'b1;
        send(8'hE6, 8'h00);
        for (n = 0; n < 20 && spin_down_req !== 1'b1; n++) @(negedge mclk);
        repeat (10) @(negedge mclk);
        check({5'h00, spin_down_req, asleep, link.cmd_ready}, 8'h04,
            "spin");
        spin_down_done = 1'b1;
        repeat (2) @(negedge mclk);
        spin_down_done = 1'b0;
        check({7'h00, asleep}, 8'h01, "asleep");
        send(8'hB0, 8'hD8);
        repeat (20) @(negedge mclk);
        check({6'h00, asleep, link.cmd_ready}, 8'h02, "stays asleep");
        wake = 1'b1;
        @(negedge mclk);
        wake = 1'b0;
        repeat (3) @(negedge mclk);
        check({6'h00, asleep, link.cmd_ready}, 8'h01, "woken");
        spindle_spinning = 1'b0;
        saw_spin = 1'b0;
        send(8'h99, 8'h00);
        for (n = 0; n < 20 && asleep !== 1'b1; n++) @(negedge mclk);
        repeat (12) @(negedge mclk);
        check({6'h00, saw_spin, asleep}, 8'h01, "direct sleep");
        wake = 1'b1;
        @(negedge mclk);
        wake = 1'b0;
        repeat (3) @(negedge mclk);
        run(8'hB0, 8'hD1);
        conclude();
    end
endmodule : test_sleep_and_smart_command_decoder
